/* File: src/stfr_receiver.sv */
// Purpose: User-protocol frame parser with watchdog, key reports and config commit.
// Assumes: Bytes arrive from a UART on the same clock as one-cycle strobes.
// Notes:   Character format settings are registers handed to the UART.
`timescale 1ns/10ps
`include "stfr_consts.svh"
module stfr_receiver
  import stfr_pkg::*;
#(
  parameter int TICK_CYC = `STFR_WDOG_TICK_CYC,  // Cycles per watchdog tick.
  parameter int NKEYS    = 12                     // Number of binary inputs.
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave.
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Received byte stream from the UART.
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_data,
  // Transmit request toward the UART.
  output logic                  tx_valid,
  output logic      [7:0]       tx_data,
  input  wire logic             tx_ready,
  // Binary inputs from pins.
  input  wire logic [NKEYS-1:0] key_pin,
  // Displayed text and frame events.
  output logic                  frame_done,
  output logic      [63:0]      text_out,
  output logic                  no_host,
  // Character format toward the UART.
  output logic                  seven_bits,
  output logic      [1:0]       parity_sel,
  output logic                  two_stops,
  output logic      [3:0]       baud_sel,
  // Configuration commit toward the interface unit.
  output logic                  cfg_send,
  output logic                  sys_restart,
  output logic                  page_mode
);
  // Configuration registers.
  // They hold the factory defaults from reset until the host rewrites them.
  logic [7:0]  start_r, dend_r, end_r, own_addr_r;
  logic [3:0]  skip1_r, skip2_r, reflen_r;
  logic [1:0]  adigits_r;
  logic [9:0]  wdog_r;
  logic [NKEYS-1:0] polarity_r;       // One selects normally-closed sensing.
  logic        menu_restart_r;        // Menu was sent back to its first item.
  logic [31:0] fb_ctrl_r;             // Fieldbus control word mirror.
  // Parser state.
  stfr_state_t state_r;
  logic [3:0]  cnt_r;                 // Symbol counter within a field.
  logic [9:0]  addr_acc_r;            // Decimal address accumulator.
  logic [63:0] text_r;                // Text being collected.
  // Watchdog state.
  logic [$clog2(TICK_CYC+1)-1:0] tick_r;
  logic [9:0]  wd_cnt_r;

  // Latest APB access phase; a write lands only while pready is also high.
  logic wr_en;
  assign wr_en = psel & penable & pwrite;

  // Mapped address check.
  logic mapped;
  always_comb begin
    case (paddr)
      `STFR_OFF_CTRL, `STFR_OFF_MARKERS, `STFR_OFF_LENGTHS, `STFR_OFF_ADDR,
      `STFR_OFF_WDOG, `STFR_OFF_POLARITY, `STFR_OFF_STATUS, `STFR_OFF_TEXT_LO,
      `STFR_OFF_TEXT_HI, `STFR_OFF_MENU, `STFR_OFF_FIELDBUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // APB answers in the access phase with no wait state; unmapped access errors.
  // Since pready is registered, each transfer takes exactly one access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // Configuration writes; menu confirmation handled here too.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r        <= `STFR_RST_START;
      dend_r         <= `STFR_RST_DEND;
      end_r          <= `STFR_RST_END;
      skip1_r        <= 4'h0;
      skip2_r        <= `STFR_RST_SKIP2;
      reflen_r       <= `STFR_RST_REFLEN;
      adigits_r      <= 2'h0;
      own_addr_r     <= 8'h00;
      wdog_r         <= 10'h000;
      polarity_r     <= '0;
      seven_bits     <= 1'b0;
      parity_sel     <= 2'h0;
      two_stops      <= 1'b0;
      baud_sel       <= `STFR_RST_BAUD;
      menu_restart_r <= 1'b0;
      fb_ctrl_r      <= 32'h0000_0000;
    end else if (wr_en && pready) begin
      case (paddr)
        // Character format: 7 or 8 bits, parity, stop bits, baud index.
        `STFR_OFF_CTRL: begin
          seven_bits <= pwdata[0];
          parity_sel <= (pwdata[2:1] == 2'h3) ? 2'h0 : pwdata[2:1];
          two_stops  <= pwdata[3];
          baud_sel   <= (pwdata[7:4] > `STFR_MAX_BAUD) ? `STFR_MAX_BAUD : pwdata[7:4];
        end
        // Frame markers: start byte, data-end byte and end byte.
        `STFR_OFF_MARKERS: begin
          start_r <= pwdata[7:0];
          dend_r  <= pwdata[15:8];
          end_r   <= pwdata[23:16];
        end
        // Field lengths; the skip-1 and text counts are clamped to what the parser can hold.
        `STFR_OFF_LENGTHS: begin
          skip1_r   <= (pwdata[3:0] > `STFR_MAX_SKIP1) ? `STFR_MAX_SKIP1 : pwdata[3:0];
          skip2_r   <= pwdata[7:4];
          reflen_r  <= (pwdata[11:8] > `STFR_MAX_REFLEN) ? `STFR_MAX_REFLEN : pwdata[11:8];
          adigits_r <= pwdata[13:12];
        end
        `STFR_OFF_ADDR: own_addr_r <= pwdata[7:0];
        // Watchdog interval in ticks; larger values are clamped to the top.
        `STFR_OFF_WDOG: begin
          wdog_r <= (pwdata[9:0] > `STFR_MAX_WDOG) ? `STFR_MAX_WDOG : pwdata[9:0];
        end
        // One polarity bit per key; a one senses a normally-closed contact.
        `STFR_OFF_POLARITY: polarity_r <= pwdata[NKEYS-1:0];
        // Menu answer: bit 0 high is Yes; anything else restarts the menu.
        `STFR_OFF_MENU: menu_restart_r <= ~pwdata[0];
        // Fieldbus control mirror; no rate field, the bus side finds the rate.
        `STFR_OFF_FIELDBUS: fb_ctrl_r <= pwdata;
        default: ;
      endcase
    end
  end

  // A Yes at the menu emits the config send, then the restart a cycle later.
  logic commit_p;
  assign commit_p = wr_en & pready & (paddr == `STFR_OFF_MENU) & pwdata[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_send    <= 1'b0;
      sys_restart <= 1'b0;
    end else begin
      cfg_send    <= commit_p;
      sys_restart <= cfg_send;
    end
  end

  // Mode select from the master's control bit 1; same layout in either mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) page_mode <= 1'b0;
    else          page_mode <= fb_ctrl_r[1];
  end

  // Frame parser.
  // An address digit is an ASCII numeral; anything above nine is no digit.
  logic [7:0] dig;
  logic [9:0] addr_sum;
  assign dig      = rx_data - 8'h30;
  assign addr_sum = 10'((addr_acc_r * 10) + {2'h0, dig});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= STFR_HUNT;
      cnt_r      <= 4'h0;
      addr_acc_r <= 10'h000;
      text_r     <= 64'h0;
      text_out   <= 64'h0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (rx_valid) begin
        case (state_r)
          STFR_HUNT: begin
            // Any other byte is ignored while hunting for the start marker.
            if (rx_data == start_r) begin
              cnt_r      <= 4'h0;
              addr_acc_r <= 10'h000;
              text_r     <= 64'h0;
              if (skip1_r != 4'h0) state_r <= STFR_SKIP1;
              else if (adigits_r != 2'h0) state_r <= STFR_ADDR;
              else state_r <= STFR_DEND;
            end
          end
          STFR_SKIP1: begin
            // Leading symbols after the start marker are counted off and dropped.
            if (cnt_r + 4'h1 >= skip1_r) begin
              cnt_r   <= 4'h0;
              state_r <= (adigits_r != 2'h0) ? STFR_ADDR : STFR_DEND;
            end else cnt_r <= cnt_r + 4'h1;
          end
          STFR_ADDR: begin
            if (dig > 8'h09) state_r <= STFR_HUNT;
            else if (cnt_r + 4'h1 >= {2'h0, adigits_r}) begin
              cnt_r <= 4'h0;
              // Own address or broadcast zero passes; others are dropped.
              if (addr_sum == {2'h0, own_addr_r} || addr_sum == 10'h000)
                state_r <= STFR_DEND;
              else state_r <= STFR_HUNT;
            end else begin
              cnt_r      <= cnt_r + 4'h1;
              addr_acc_r <= addr_sum;
            end
          end
          STFR_DEND: begin
            // Bytes before the data-end marker are dropped whatever they hold.
            if (rx_data == dend_r) begin
              cnt_r   <= 4'h0;
              state_r <= (skip2_r != 4'h0) ? STFR_SKIP2
                       : (reflen_r != 4'h0) ? STFR_TEXT : STFR_TAIL;
            end
          end
          STFR_SKIP2: begin
            // The second skip run is counted off the same way.
            if (cnt_r + 4'h1 >= skip2_r) begin
              cnt_r   <= 4'h0;
              state_r <= (reflen_r != 4'h0) ? STFR_TEXT : STFR_TAIL;
            end else cnt_r <= cnt_r + 4'h1;
          end
          STFR_TEXT: begin
            // Characters are packed first-received in the low byte.
            text_r[cnt_r[2:0]*8 +: 8] <= rx_data;
            if (cnt_r + 4'h1 >= reflen_r) begin
              cnt_r   <= 4'h0;
              state_r <= STFR_TAIL;
            end else cnt_r <= cnt_r + 4'h1;
          end
          STFR_TAIL: begin
            // Bytes other than the end marker are ignored until it arrives.
            if (rx_data == end_r) begin
              text_out   <= text_r;
              frame_done <= 1'b1;
              state_r    <= STFR_HUNT;
            end
          end
          default: state_r <= STFR_HUNT;
        endcase
      end
    end
  end

  // Watchdog: counts ticks since the last byte; zero interval disables it.
  // The tick prescaler keeps the interval counter narrow at any clock rate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r   <= '0;
      wd_cnt_r <= 10'h000;
      no_host  <= 1'b0;
    end else if (rx_valid) begin
      tick_r   <= '0;
      wd_cnt_r <= 10'h000;
      no_host  <= 1'b0;
    end else if (wdog_r != 10'h000) begin
      if (tick_r == ($bits(tick_r))'(TICK_CYC - 1)) begin
        tick_r <= '0;
        if (wd_cnt_r + 10'h001 >= wdog_r) no_host <= 1'b1;
        else wd_cnt_r <= wd_cnt_r + 10'h001;
      end else tick_r <= tick_r + 1'b1;
    end
  end

  // Key inputs: three-stage synchroniser, polarity mask, agreement filter.
  // Waiting for two stages to agree keeps a metastable sample out of reports.
  logic [NKEYS-1:0] k1_r, k2_r, k3_r, key_r, active;
  genvar gi;
  generate
    for (gi = 0; gi < NKEYS; gi++) begin : g_key
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          k1_r[gi]  <= 1'b0;
          k2_r[gi]  <= 1'b0;
          k3_r[gi]  <= 1'b0;
          key_r[gi] <= 1'b0;
        end else begin
          k1_r[gi] <= key_pin[gi];
          k2_r[gi] <= k1_r[gi];
          k3_r[gi] <= k2_r[gi];
          if (k2_r[gi] == k3_r[gi]) key_r[gi] <= k3_r[gi] ^ polarity_r[gi];
        end
      end
      assign active[gi] = key_r[gi];
    end
  endgenerate

  // Key reporter: lowest newly active key sends '0' plus its index (':' and ';' for keys 10 and 11), a release sends '0'.
  // A new report waits while the previous one is still pending toward the host.
  logic [NKEYS-1:0] sent_r;
  logic [7:0]       rep;
  logic             rep_v;
  logic [NKEYS-1:0] rep_mask;
  always_comb begin
    rep_v    = 1'b0;
    rep      = `STFR_ASCII_ZERO;
    rep_mask = sent_r;
    for (int i = NKEYS - 1; i >= 0; i--) begin
      if (active[i] != sent_r[i]) begin
        rep_v       = 1'b1;
        rep_mask    = sent_r;
        rep_mask[i] = active[i];
        rep = active[i] ? 8'(`STFR_ASCII_ZERO + i) : `STFR_ASCII_ZERO;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_r   <= '0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end else if (tx_valid) begin
      if (tx_ready) tx_valid <= 1'b0;
    end else if (rep_v) begin
      tx_valid <= 1'b1;
      tx_data  <= rep;
      sent_r   <= rep_mask;
    end
  end

  // Fieldbus area sizes, shown in the top bits of the status word.
  localparam logic [5:0] FB_OUT = 6'(`STFR_FB_OUT_BYTES);
  localparam logic [2:0] FB_IN  = 3'(`STFR_FB_IN_BYTES);
  // Register read data, loaded in the setup cycle so it stands in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `STFR_OFF_CTRL:     prdata <= {24'h0, baud_sel, two_stops, parity_sel, seven_bits};
        `STFR_OFF_MARKERS:  prdata <= {8'h0, end_r, dend_r, start_r};
        `STFR_OFF_LENGTHS:  prdata <= {18'h0, adigits_r, reflen_r, skip2_r, skip1_r};
        `STFR_OFF_ADDR:     prdata <= {24'h0, own_addr_r};
        `STFR_OFF_WDOG:     prdata <= {22'h0, wdog_r};
        `STFR_OFF_POLARITY: prdata <= {{(32-NKEYS){1'b0}}, polarity_r};
        // Status: fieldbus area sizes on top, then the keys, then the flags.
        `STFR_OFF_STATUS:   prdata <= ({{(32-NKEYS){1'b0}}, active} << 8)
                                      | {FB_OUT, FB_IN, 23'h0}
                                      | {28'h0, menu_restart_r, page_mode, frame_done, no_host};
        `STFR_OFF_TEXT_LO:  prdata <= text_out[31:0];
        `STFR_OFF_TEXT_HI:  prdata <= text_out[63:32];
        `STFR_OFF_MENU:     prdata <= {31'h0, menu_restart_r};
        `STFR_OFF_FIELDBUS: prdata <= fb_ctrl_r;
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : stfr_receiver

/* File: src/stfr_consts.svh */
// Purpose: Constants for the serial text frame receiver.
// Assumes: 10 MHz pclk, 32-bit APB register words.
// Notes:   Offsets are byte addresses of aligned words.
`ifndef STFR_CONSTS_SVH
`define STFR_CONSTS_SVH
`define STFR_OFF_CTRL      12'h000
`define STFR_OFF_MARKERS   12'h004
`define STFR_OFF_LENGTHS   12'h008
`define STFR_OFF_ADDR      12'h00c
`define STFR_OFF_WDOG      12'h010
`define STFR_OFF_POLARITY  12'h014
`define STFR_OFF_STATUS    12'h018
`define STFR_OFF_TEXT_LO   12'h01c
`define STFR_OFF_TEXT_HI   12'h020
`define STFR_OFF_MENU      12'h024
`define STFR_OFF_FIELDBUS  12'h028
`define STFR_RST_START     8'h02
`define STFR_RST_DEND      8'h09
`define STFR_RST_END       8'h03
`define STFR_RST_SKIP2     4'h2
`define STFR_RST_REFLEN    4'h6
`define STFR_RST_BAUD      4'h4
`define STFR_MAX_BAUD      4'h8
`define STFR_MAX_REFLEN    4'h8
`define STFR_MAX_SKIP1     4'h9
`define STFR_MAX_ADIGITS   2'h3
`define STFR_MAX_WDOG      10'h3e7
`define STFR_ASCII_ZERO    8'h30
`define STFR_WDOG_TICK_MS  1
`define STFR_CLK_HZ        10000000
`define STFR_WDOG_TICK_CYC ((`STFR_CLK_HZ / 1000) * `STFR_WDOG_TICK_MS)
`define STFR_FB_OUT_BYTES  34
`define STFR_FB_IN_BYTES   4
`define STFR_FB_MAX_KBPS   12000
`endif

/* File: src/stfr_pkg.sv */
// Purpose: Types for the serial text frame receiver.
// Assumes: Used together with stfr_consts.svh.
// Notes:   States carry no explicit codes.
package stfr_pkg;
  typedef enum logic [2:0] {
    STFR_HUNT, STFR_SKIP1, STFR_ADDR, STFR_DEND, STFR_SKIP2, STFR_TEXT, STFR_TAIL
  } stfr_state_t;
  typedef enum logic [1:0] {STFR_PAR_NONE, STFR_PAR_EVEN, STFR_PAR_ODD} stfr_parity_t;
endpackage : stfr_pkg

/* File: verif/stfr_receiver_monitor.sv */
// Purpose: Port checker for stfr_receiver.
// Assumes: One clock domain reset by presetn.
// Notes:   Bound onto the receiver below.
`timescale 1ns/10ps
module stfr_receiver_monitor (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Bus handshake.
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Stream, link and commit.
  input wire logic       rx_valid,
  input wire logic       frame_done,
  input wire logic       no_host,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  input wire logic       cfg_send,
  input wire logic       sys_restart
);
  // Every check samples on pclk and rests in reset.
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  bus_answer_a: assert property (psel && !penable |=> pready)
    else $error("bus answer late");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  done_pulse_a: assert property (frame_done |=> !frame_done)
    else $error("frame done too long");
  done_cause_a: assert property (frame_done |-> $past(rx_valid))
    else $error("frame done without byte");
  link_back_a: assert property (rx_valid |=> !no_host)
    else $error("lost link kept");
  link_hold_a: assert property (no_host && !rx_valid |=> no_host)
    else $error("lost link dropped");
  link_set_a: assert property ($rose(no_host) |-> !$past(rx_valid))
    else $error("lost link after data");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit not held");
  commit_seq_a: assert property (cfg_send |=> sys_restart && !cfg_send)
    else $error("restart not after send");
  restart_cause_a: assert property (sys_restart |-> $past(cfg_send))
    else $error("restart without send");
endmodule : stfr_receiver_monitor
bind stfr_receiver stfr_receiver_monitor u_stfr_receiver_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
  .frame_done(frame_done), .no_host(no_host), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .cfg_send(cfg_send),
  .sys_restart(sys_restart));

/* File: verif/stfr_host_model.sv */
// Purpose: Host side UART model for the receiver.
// Assumes: Bytes travel as one-cycle strobes.
// Notes:   Acceptance of sent bytes can stall.
`timescale 1ns/10ps
module stfr_host_model (
  // Clock.
  input  wire logic       pclk,
  // Bytes toward the block.
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // Bytes from the block.
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  // Accepted key reports, oldest first; only one unit sits on this link.
  logic [7:0] got[$];
  int         stall = 0; // Cycles held off per byte.
  int         held = 0;  // Cycles held off so far.
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Sends a frame; idle data shows the inverse of the last byte.
  task automatic send(input logic [7:0] q[$], input int gap);
    for (int i = 0; i < q.size(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= q[i];
      @(posedge pclk);
      if (gap > 0 || i == q.size() - 1) begin
        rx_valid <= 1'b0;
        rx_data <= ~q[i];
        repeat ((i == q.size() - 1) ? 1 : gap) @(posedge pclk);
      end
    end
  endtask : send
  // Takes a byte once the stall has run out.
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    tx_ready <= tx_valid && !tx_ready && held >= stall;
    held = (tx_valid && !tx_ready) ? held + 1 : 0;
  end
endmodule : stfr_host_model

/* File: verif/serial_text_frame_receiver_bench.sv */
// Purpose: Self-checking bench for stfr_receiver.
// Assumes: Watchdog tick shortened to 4 cycles.
// Notes:   Host side is stfr_host_model.
`timescale 1ns/10ps
`include "stfr_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %0h want %0h", $time, g, e); end end
module serial_text_frame_receiver_bench import stfr_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0;  // Clock and reset.
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, rx_valid, tx_valid, tx_ready;
  logic [7:0]  rx_data, tx_data, b;
  logic [11:0] key_pin = 12'h000;              // Key pins, active high.
  logic        frame_done, no_host, seven_bits, two_stops, cfg_send;
  logic        sys_restart, page_mode, seen;
  logic [63:0] text_out;
  logic [1:0]  parity_sel;
  logic [3:0]  baud_sel;
  int          bad_count = 0, checks = 0, n;
  stfr_receiver #(.TICK_CYC(4)) u_stfr_receiver (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .key_pin(key_pin), .frame_done(frame_done), .text_out(text_out),
    .no_host(no_host), .seven_bits(seven_bits), .parity_sel(parity_sel),
    .two_stops(two_stops), .baud_sel(baud_sel), .cfg_send(cfg_send),
    .sys_restart(sys_restart), .page_mode(page_mode));
  stfr_host_model u_host (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // A 100 ns clock.
  always #50 pclk = ~pclk;
  // Prints the verdict and ends the run.
  task automatic conclude;
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // Reports a hang and stops.
  task automatic fail(input string m);
    $display("[ERR] %0t %s", $time, m);
    bad_count++;
    conclude;
  endtask : fail
  // One bus transfer, held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) fail("bus hang");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Read with expected data and error flag.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
    `CHK(rerr, er)
  endtask : rd
  // Sends a frame with six text bytes, a stray byte and the end byte.
  task automatic frame(input logic [7:0] q[$], input logic [47:0] t, input int gap,
                       input logic ok, input logic [47:0] e);
    for (int i = 0; i < 6; i++) q.push_back(t[8*i +: 8]);
    q.push_back(8'h7e);
    q.push_back(8'h03);
    u_host.send(q, gap);
    seen = (frame_done === 1'b1);
    repeat (2) @(posedge pclk) seen = seen | (frame_done === 1'b1);
    `CHK(seen, ok)
    `CHK(text_out[47:0], e)
  endtask : frame
  // Waits for one sent byte and compares it.
  task automatic txchk(input logic [7:0] e);
    n = 0;
    while (u_host.got.size() == 0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (u_host.got.size() == 0) fail("no byte sent");
    b = u_host.got.pop_front();
    `CHK(b, e)
  endtask : txchk
  // Cuts a hung run short.
  initial begin
    #6000000;
    fail("run timeout");
  end
  // Main sequence.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(baud_sel, `STFR_RST_BAUD)
    rd(`STFR_OFF_MARKERS, 32'h0003_0902, 1'b0);
    rd(`STFR_OFF_LENGTHS, 32'h0000_0620, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, `STFR_OFF_CTRL, {24'h0, 4'h8, 1'b1, 2'(p), 1'b1});
      @(posedge pclk);
      `CHK(parity_sel, 2'(p))
    end
    `CHK({seven_bits, two_stops, baud_sel}, 6'h38)
    frame({8'h55, 8'h02, 8'h09, 8'h11, 8'h22}, 48'h464544434241, 0, 1'b1,
          48'h464544434241);
    apb(1'b1, `STFR_OFF_LENGTHS, 32'h0000_2621);
    apb(1'b1, `STFR_OFF_ADDR, 32'h0000_000c);
    frame({8'h02, 8'h78, 8'h31, 8'h32, 8'h71, 8'h09, 8'h41, 8'h42}, 48'h4c4b4a494847,
          0, 1'b1, 48'h4c4b4a494847);
    frame({8'h02, 8'h78, 8'h31, 8'h33, 8'h09, 8'h41, 8'h42}, 48'h52514f4e4d4c, 0,
          1'b0, 48'h4c4b4a494847);
    frame({8'h02, 8'h78, 8'h30, 8'h30, 8'h09, 8'h41, 8'h42}, 48'h585756555453, 2,
          1'b1, 48'h585756555453);
    rd(`STFR_OFF_TEXT_LO, 32'h5655_5453, 1'b0);
    rd(`STFR_OFF_TEXT_HI, 32'h0000_5857, 1'b0);
    apb(1'b1, `STFR_OFF_WDOG, 32'h0000_0003);
    u_host.send({8'h41}, 0);
    repeat (6) @(posedge pclk);
    `CHK(no_host, 1'b0)
    n = 0;
    while (no_host !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    `CHK(no_host, 1'b1)
    u_host.send({8'h41}, 0);
    `CHK(no_host, 1'b0)
    apb(1'b1, `STFR_OFF_WDOG, 32'h0);
    u_host.stall = 3;
    key_pin <= 12'h020;
    txchk(8'h35);
    key_pin <= 12'h000;
    txchk(8'h30);
    apb(1'b1, `STFR_OFF_POLARITY, 32'h0000_0008);
    txchk(8'h33);
    apb(1'b1, `STFR_OFF_POLARITY, 32'h0);
    txchk(8'h30);
    apb(1'b1, `STFR_OFF_MENU, 32'h0);
    seen = 1'b0;
    repeat (4) @(posedge pclk) seen = seen | (cfg_send === 1'b1);
    `CHK(seen, 1'b0)
    rd(`STFR_OFF_MENU, 32'h1, 1'b0);
    apb(1'b1, `STFR_OFF_MENU, 32'h1);
    n = 0;
    while (cfg_send !== 1'b1 && n < 6) begin
      @(posedge pclk);
      n++;
    end
    `CHK(cfg_send, 1'b1)
    @(posedge pclk);
    `CHK(sys_restart, 1'b1)
    rd(`STFR_OFF_MENU, 32'h0, 1'b0);
    apb(1'b1, `STFR_OFF_FIELDBUS, 32'h2);
    @(posedge pclk);
    `CHK(page_mode, 1'b1)
    rd(`STFR_OFF_STATUS, {6'(`STFR_FB_OUT_BYTES), 3'(`STFR_FB_IN_BYTES), 23'h4}, 1'b0);
    conclude;
  end
endmodule : serial_text_frame_receiver_bench
